// *** include/atsc_defs.vh ***
// Constants for the converter and temperature sensor control block.
// Assumes inclusion by bare name from rtl files; holds definitions only.
`ifndef ATSC_DEFS_VH
`define ATSC_DEFS_VH

// Register indices (printed offsets), byte address is four times these
`define ATSC_IDX_CFG        8'h0f
`define ATSC_IDX_AOFFS      8'h10
`define ATSC_IDX_RESULT     8'h11
`define ATSC_IDX_TCAL       8'h12
`define ATSC_IDX_TVOFFS     8'h13
`define ATSC_IDX_IRQ_STAT   8'h20
`define ATSC_IDX_IRQ_EN     8'h21
`define ATSC_IDX_IRQ_CLR    8'h22

// Configuration register fields
`define ATSC_CFG_START      7
`define ATSC_SEL_HI         6
`define ATSC_SEL_LO         4
`define ATSC_REF_HI         3
`define ATSC_REF_LO         2
`define ATSC_GAIN_HI        1
`define ATSC_GAIN_LO        0

// Source codes
`define ATSC_SRC_TEMP       3'h0
`define ATSC_SRC_P0         3'h1
`define ATSC_SRC_P2         3'h2
`define ATSC_SRC_D01        3'h4
`define ATSC_SRC_D12        3'h5
`define ATSC_SRC_D02        3'h6
`define ATSC_SRC_GND        3'h7

// Reference codes (reference ignores low bit when high bit is zero; coefficient select still uses it)
`define ATSC_REF_VDD3       2'h2
`define ATSC_REF_VDD2       2'h3

// Amplifier offset field
`define ATSC_AOFFS_SIGN     3
`define ATSC_AOFFS_MASK     8'h0f

// Calibration register fields
`define ATSC_TCAL_RNG_HI    7
`define ATSC_TCAL_RNG_LO    6
`define ATSC_TCAL_KOFFS     5
`define ATSC_TCAL_TRIMEN    4
`define ATSC_TCAL_TRIM_HI   3
`define ATSC_TCAL_RESET     8'h20

// Temperature range codes
`define ATSC_RNG_C_HALF     2'h0
`define ATSC_RNG_C_ONE      2'h1
`define ATSC_RNG_F_ONE      2'h2
`define ATSC_RNG_C_POS      2'h3

// Interrupt bits
`define ATSC_IRQ_DONE       0
`define ATSC_IRQ_W          2

// Conversion time
`define ATSC_CONV_NS        350
`define ATSC_CLK_NS         5
// 350 ns at a 5 ns clock, sized to the counter so nothing is cut silently
`define ATSC_CONV_CYC       7'd70
`define ATSC_CNT_W          7

`endif

// *** rtl/atsc_ctrl.v ***
// Register control for an 8-bit converter with temperature sensor path.
// Assumes an APB master on REF_CLK_I, analog front end outside this block
// presenting a sample word on SAMPLE_I, synchronous to REF_CLK_I.
`timescale 1ns/100ps
`include "atsc_defs.vh"

module atsc_ctrl (
	// Clock and reset
	input  wire        REF_CLK_I,
	input  wire        RST_I,
	// APB slave
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output reg  [31:0] PRDATA_O,
	output reg         PREADY_O,
	output reg         PSLVERR_O,
	// Analog front end
	input  wire [7:0]  SAMPLE_I,
	output reg         SAMPLE_REQ_O,
	output reg  [2:0]  SRC_SEL_O,
	output reg  [1:0]  REF_SEL_O,
	output reg  [1:0]  GAIN_SEL_O,
	output reg         DIFF_MODE_O,
	output reg         FS_COEF_HI_O,
	output reg         AOFFS_NEG_O,
	output reg  [2:0]  AOFFS_MAG_O,
	output reg  [1:0]  TS_RANGE_O,
	output reg         TS_KOFFS_EN_O,
	output reg         TS_TRIM_EN_O,
	output reg  [3:0]  TS_TRIM_O,
	// Interrupt
	output reg         IRQ_O
);

	localparam ST_IDLE = 1'b0;
	localparam ST_CONV = 1'b1;
	localparam [`ATSC_CNT_W-1:0] CONV_CYC = `ATSC_CONV_CYC;

	reg                    state_r;
	reg                    done_r;
	reg  [`ATSC_CNT_W-1:0] cnt_r;
	reg  [7:0]             cfg_r;
	reg  [3:0]             aoffs_r;
	reg  [7:0]             result_r;
	reg  [7:0]             tcal_r;
	reg  [7:0]             tvoffs_r;
	reg  [`ATSC_IRQ_W-1:0] irq_stat_r;
	reg  [`ATSC_IRQ_W-1:0] irq_en_r;
	reg  [31:0]            rdata_nxt;
	reg                    err_nxt;

	wire       acc     = PSEL_I & PENABLE_I & PREADY_O;
	wire       wr      = acc & PWRITE_I;
	wire [7:0] idx     = PADDR_I[9:2];
	wire       aligned = (PADDR_I[1:0] == 2'h0) & (PADDR_I[11:10] == 2'h0);
	wire       start   = wr & aligned & (idx == `ATSC_IDX_CFG) & PWDATA_I[`ATSC_CFG_START];
	wire       finish  = (state_r == ST_CONV) && (cnt_r == CONV_CYC);
	wire [2:0] src     = cfg_r[`ATSC_SEL_HI:`ATSC_SEL_LO];
	wire [1:0] refsel  = cfg_r[`ATSC_REF_HI:`ATSC_REF_LO];
	wire       setup   = PSEL_I & ~PENABLE_I;
	wire       wr_ok   = wr & aligned;

	// Per-register write strobes, taken at the completing edge
	wire       wr_cfg     = wr_ok & (idx == `ATSC_IDX_CFG);
	wire       wr_aoffs   = wr_ok & (idx == `ATSC_IDX_AOFFS);
	wire       wr_tcal    = wr_ok & (idx == `ATSC_IDX_TCAL);
	wire       wr_tvoffs  = wr_ok & (idx == `ATSC_IDX_TVOFFS);
	wire       wr_irq_en  = wr_ok & (idx == `ATSC_IDX_IRQ_EN);
	wire       wr_irq_clr = wr_ok & (idx == `ATSC_IDX_IRQ_CLR);

	// Field views of the stored settings
	wire [1:0] gain       = cfg_r[`ATSC_GAIN_HI:`ATSC_GAIN_LO];
	wire       ref_hi     = refsel[1];
	wire       aoffs_neg  = aoffs_r[`ATSC_AOFFS_SIGN];
	wire [2:0] aoffs_mag  = aoffs_r[`ATSC_AOFFS_SIGN-1:0];
	wire [1:0] ts_range   = tcal_r[`ATSC_TCAL_RNG_HI:`ATSC_TCAL_RNG_LO];
	wire       ts_koffs   = tcal_r[`ATSC_TCAL_KOFFS];
	wire       ts_trim_en = tcal_r[`ATSC_TCAL_TRIMEN];
	wire [3:0] ts_trim    = tcal_r[`ATSC_TCAL_TRIM_HI:0];
	wire       irq_pend   = |(irq_stat_r & irq_en_r);

	// Offset applies to sensor readings only; wraps on overflow
	wire [7:0] sample_fix = (src == `ATSC_SRC_TEMP) ? SAMPLE_I + tvoffs_r : SAMPLE_I;
	wire [`ATSC_IRQ_W-1:0] irq_ev = {1'b0, finish};

	////////////////////////////////////////////////////////////////////////
	// APB read mux and decode

	always @* begin
		rdata_nxt = 32'h0000_0000;
		err_nxt   = 1'b0;
		if (!aligned) begin
			err_nxt = 1'b1;
		end else begin
			case (idx)
				`ATSC_IDX_CFG: begin
					rdata_nxt = {24'h000000, done_r, cfg_r[6:0]};
				end
				`ATSC_IDX_AOFFS: begin
					rdata_nxt = {28'h0000000, aoffs_r};
				end
				`ATSC_IDX_RESULT: begin
					rdata_nxt = {24'h000000, result_r};
				end
				`ATSC_IDX_TCAL: begin
					rdata_nxt = {24'h000000, tcal_r};
				end
				`ATSC_IDX_TVOFFS: begin
					rdata_nxt = {24'h000000, tvoffs_r};
				end
				`ATSC_IDX_IRQ_STAT: begin
					rdata_nxt = {30'h00000000, irq_stat_r};
				end
				`ATSC_IDX_IRQ_EN: begin
					rdata_nxt = {30'h00000000, irq_en_r};
				end
				`ATSC_IDX_IRQ_CLR: begin
					rdata_nxt = 32'h0000_0000;
				end
				default: begin
					err_nxt = 1'b1;
				end
			endcase
		end
	end

	// Zero wait: ready rises in the access cycle, one answer per transfer
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PREADY_O <= 1'b0;
		end else begin
			PREADY_O <= setup;
		end
	end

	// Error answers with ready, so a refused transfer still completes
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PSLVERR_O <= 1'b0;
		end else begin
			PSLVERR_O <= setup & err_nxt;
		end
	end

	// Read data captured in setup, valid while ready stands
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (setup & ~PWRITE_I) begin
			PRDATA_O <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers software writes

	// Start bit is a strobe, only the setting bits are kept
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cfg_r <= 8'h00;
		end else if (wr_cfg) begin
			cfg_r <= {1'b0, PWDATA_I[`ATSC_CFG_START-1:0]};
		end
	end

	// Reserved upper bits of the amplifier offset are not stored
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			aoffs_r <= 4'h0;
		end else if (wr_aoffs) begin
			aoffs_r <= PWDATA_I[`ATSC_AOFFS_SIGN:0];
		end
	end

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tcal_r <= `ATSC_TCAL_RESET;
		end else if (wr_tcal) begin
			tcal_r <= PWDATA_I[7:0];
		end
	end

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tvoffs_r <= 8'h00;
		end else if (wr_tvoffs) begin
			tvoffs_r <= PWDATA_I[7:0];
		end
	end

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			irq_en_r <= {`ATSC_IRQ_W{1'b0}};
		end else if (wr_irq_en) begin
			irq_en_r <= PWDATA_I[`ATSC_IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer

	// A start during a running conversion restarts it; settings are assumed
	// steady meanwhile, so no shadow copy is taken
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= ST_IDLE;
			cnt_r   <= {`ATSC_CNT_W{1'b0}};
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= ST_CONV;
						cnt_r   <= {`ATSC_CNT_W{1'b0}};
					end
				end
				ST_CONV: begin
					if (start) begin
						cnt_r <= {`ATSC_CNT_W{1'b0}};
					end else if (finish) begin
						state_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Request pulse marks every launch, restarts included
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			SAMPLE_REQ_O <= 1'b0;
		end else begin
			SAMPLE_REQ_O <= start;
		end
	end

	// Done clears on start and sets when the result lands; start wins
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			done_r   <= 1'b0;
			result_r <= 8'h00;
		end else if (start) begin
			done_r <= 1'b0;
		end else if (finish) begin
			result_r <= sample_fix;
			done_r   <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Front end steering

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			SRC_SEL_O   <= 3'h0;
			DIFF_MODE_O <= 1'b0;
		end else begin
			SRC_SEL_O   <= src;
			DIFF_MODE_O <= src[2] & (src != `ATSC_SRC_GND);
		end
	end

	// Bandgap whenever the high bit is clear; coefficient follows bit 0 alone
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			REF_SEL_O    <= 2'h0;
			GAIN_SEL_O   <= 2'h0;
			FS_COEF_HI_O <= 1'b0;
		end else begin
			REF_SEL_O    <= ref_hi ? refsel : 2'h0;
			GAIN_SEL_O   <= gain;
			FS_COEF_HI_O <= refsel[0];
		end
	end

	// Passed on as sign and magnitude, the front end does the arithmetic
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			AOFFS_NEG_O <= 1'b0;
			AOFFS_MAG_O <= 3'h0;
		end else begin
			AOFFS_NEG_O <= aoffs_neg;
			AOFFS_MAG_O <= aoffs_mag;
		end
	end

	// Kelvin offset enable idles high, matching the calibration reset value
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			TS_RANGE_O    <= 2'h0;
			TS_KOFFS_EN_O <= 1'b1;
			TS_TRIM_EN_O  <= 1'b0;
			TS_TRIM_O     <= 4'h0;
		end else begin
			TS_RANGE_O    <= ts_range;
			TS_KOFFS_EN_O <= ts_koffs;
			TS_TRIM_EN_O  <= ts_trim_en;
			TS_TRIM_O     <= ts_trim;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over clear

	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			irq_stat_r <= {`ATSC_IRQ_W{1'b0}};
		end else if (wr_irq_clr) begin
			irq_stat_r <= (irq_stat_r & ~PWDATA_I[`ATSC_IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat_r <= irq_stat_r | irq_ev;
		end
	end

	// Level output trails the status by one edge
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= irq_pend;
		end
	end

endmodule

// *** bench/atsc_ctrl_monitor.sv ***
// Checker for the converter control block: register to output relations.
// Bound to atsc_ctrl; sees its ports only, one clock domain.
`timescale 1ns/100ps
module atsc_ctrl_mon (
	// Clock, reset and bus
	input wire        REF_CLK_I,
	input wire        RST_I,
	input wire        PSEL_I,
	input wire        PENABLE_I,
	input wire        PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [31:0] PRDATA_O,
	input wire        PREADY_O,
	// Front end controls
	input wire        SAMPLE_REQ_O,
	input wire [2:0]  SRC_SEL_O,
	input wire [1:0]  REF_SEL_O,
	input wire [1:0]  GAIN_SEL_O,
	input wire        DIFF_MODE_O,
	input wire        FS_COEF_HI_O,
	input wire        AOFFS_NEG_O,
	input wire [2:0]  AOFFS_MAG_O,
	input wire [1:0]  TS_RANGE_O,
	input wire        TS_KOFFS_EN_O,
	input wire        TS_TRIM_EN_O,
	input wire [3:0]  TS_TRIM_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	wire acc = PSEL_I & PENABLE_I & PREADY_O;
	wire wr_cfg = acc & PWRITE_I & (PADDR_I == 12'h03c);
	wire wr_aof = acc & PWRITE_I & (PADDR_I == 12'h040);
	wire wr_cal = acc & PWRITE_I & (PADDR_I == 12'h048);
	wire rd_cfg = acc & !PWRITE_I & (PADDR_I == 12'h03c);
	sequence s_launch; wr_cfg && PWDATA_I[7]; endsequence
	sequence s_pulse; SAMPLE_REQ_O ##1 !SAMPLE_REQ_O; endsequence
	a_start_pulse: assert property (s_launch |=> s_pulse)
		else $error("start write gave no pulse");
	a_pulse_cause: assert property (SAMPLE_REQ_O |-> $past(wr_cfg && PWDATA_I[7]))
		else $error("pulse without start write");
	a_busy_read: assert property (SAMPLE_REQ_O ##[1:60] rd_cfg |-> !PRDATA_O[7])
		else $error("done read high while busy");
	a_cfg_follow: assert property (wr_cfg |-> ##2 ({SRC_SEL_O, GAIN_SEL_O}
		== {$past(PWDATA_I[6:4], 2), $past(PWDATA_I[1:0], 2)}) && (REF_SEL_O ==
		($past(PWDATA_I[3], 2) ? $past(PWDATA_I[3:2], 2) : 2'h0)))
		else $error("config outputs wrong");
	a_diff_mode: assert property (DIFF_MODE_O == (SRC_SEL_O[2] && SRC_SEL_O != 3'h7))
		else $error("differential flag wrong");
	a_coef_tie: assert property (wr_cfg |-> ##2 FS_COEF_HI_O == $past(PWDATA_I[2], 2))
		else $error("coefficient select wrong");
	a_aoffs_follow: assert property (wr_aof |-> ##2 {AOFFS_NEG_O, AOFFS_MAG_O}
		== $past(PWDATA_I[3:0], 2)) else $error("offset outputs wrong");
	a_cal_follow: assert property (wr_cal |-> ##2 {TS_RANGE_O, TS_KOFFS_EN_O,
		TS_TRIM_EN_O, TS_TRIM_O} == $past(PWDATA_I[7:0], 2)) else $error("cal outputs wrong");
endmodule
bind atsc_ctrl atsc_ctrl_mon u_mon (.*);

// *** bench/atsc_ctrl_bench.sv ***
// Self-checking bench for the converter control block.
// Drives APB and the sample input directly; no partner model.
`timescale 1ns/100ps
module atsc_ctrl_bench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         psel = 1'b0;
	reg         pen = 1'b0;
	reg         pwr = 1'b0;
	reg  [11:0] pa = 12'h000;
	reg  [31:0] pwd = 32'h0;
	reg  [7:0]  smp = 8'h00;
	reg  [31:0] rd;
	reg         er;
	wire [31:0] prd;
	wire        rdy, err, req, diff, coef, aneg, ken, ten, irq;
	wire [2:0]  src, amag;
	wire [1:0]  rsel, gsel, rng;
	wire [3:0]  trim;
	integer     miscompares = 0;
	integer     checks_done = 0;
	integer     i;
	always #2.5 clk = ~clk;
	atsc_ctrl dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
		.PSLVERR_O(err), .SAMPLE_I(smp), .SAMPLE_REQ_O(req), .SRC_SEL_O(src),
		.REF_SEL_O(rsel), .GAIN_SEL_O(gsel), .DIFF_MODE_O(diff), .FS_COEF_HI_O(coef),
		.AOFFS_NEG_O(aneg), .AOFFS_MAG_O(amag), .TS_RANGE_O(rng), .TS_KOFFS_EN_O(ken),
		.TS_TRIM_EN_O(ten), .TS_TRIM_O(trim), .IRQ_O(irq));
	////////////////////////////////////////////////////////////////////////////
	task conclude; begin
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end endtask
	task chk(input [63:0] got, input [63:0] exp); begin
		checks_done = checks_done + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	end endtask
	// Caller enters just after an edge; one idle edge follows each transfer
	task apb(input w, input [7:0] idx, input [31:0] d); begin
		psel <= 1'b1;
		pwr <= w;
		pa <= {2'b00, idx, 2'b00};
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		rd = prd;
		er = err;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	end endtask
	task run(input [7:0] c, input [7:0] e); begin
		apb(1'b1, 8'h0f, {24'h0, c});
		apb(1'b0, 8'h0f, 32'h0);
		chk(rd & 32'h80, 32'h0);
		while (rd[7] !== 1'b1) apb(1'b0, 8'h0f, 32'h0);
		apb(1'b0, 8'h11, 32'h0);
		chk(rd, {24'h0, e});
	end endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#50000;
		miscompares = miscompares + 1;
		conclude;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, 8'h12, 32'h0);
		chk({rd[7:0], 7'h0, ken}, 16'h2001);
		for (i = 0; i < 8; i = i + 1) begin
			apb(1'b1, 8'h0f, {25'h0, i[2:0], i[1:0], i[1:0]});
			@(posedge clk);
			chk({src, rsel, gsel, diff, coef}, {i[2:0], (i[1] ? i[1:0] : 2'h0), i[1:0],
				i[2] && i[1:0] != 2'h3, i[0]});
		end
		apb(1'b1, 8'h10, 32'hfb);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd, aneg, amag}, {32'hb, 4'hb});
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b1, 8'h12, {24'h0, i[1:0], 2'h1, i[1:0], i[1:0]});
			apb(1'b0, 8'h12, 32'h0);
			chk({rd[7:0], rng, ken, ten, trim}, {2{i[1:0], 2'h1, i[1:0], i[1:0]}});
		end
		apb(1'b1, 8'h13, 32'hfe);
		smp <= 8'h05;
		run(8'h80, 8'h03);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 8'h21, 32'h1);
		smp <= 8'h5a;
		run(8'h90, 8'h5a);
		apb(1'b0, 8'h20, 32'h0);
		chk({rd, irq}, {32'h1, 1'b1});
		apb(1'b1, 8'h22, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 8'h11, 32'hff);
		apb(1'b0, 8'h11, 32'h0);
		chk(rd, 32'h5a);
		apb(1'b0, 8'h30, 32'h0);
		chk({rd, er}, {32'h0, 1'b1});
		conclude;
	end
endmodule
